// ### rtl/fct_defines.svh
/*
  Register offsets, bit positions, reset values and prescaler taps of the free counter timer.
  Assumes an 8-bit register bus addressed by a 4-bit byte offset within the timer block.
*/
`ifndef FCT_DEFINES_SVH
`define FCT_DEFINES_SVH

// ****************************************
// Byte offsets
// ****************************************
`define FCT_OFS_STATUS 4'h1
`define FCT_OFS_CNT_HI 4'h2
`define FCT_OFS_CNT_LO 4'h3
`define FCT_OFS_CMP_HI 4'h4
`define FCT_OFS_CMP_LO 4'h5
`define FCT_OFS_CTRL 4'h6
`define FCT_OFS_OUTCTL 4'h7
`define FCT_OFS_CAP_HI 4'h8
`define FCT_OFS_CAP_LO 4'h9

// ****************************************
// Bit positions
// ****************************************
`define FCT_BIT_CAP_FLAG 7
`define FCT_BIT_MATCH_A_FLAG 3
`define FCT_BIT_MATCH_B_FLAG 2
`define FCT_BIT_WRAP_FLAG 1
`define FCT_BIT_CLEAR_ON_A 0
`define FCT_BIT_EDGE_SEL 7
`define FCT_BIT_CKS_HI 1
`define FCT_BIT_CKS_LO 0
`define FCT_BIT_REG_SEL 4
`define FCT_BIT_LEVEL_A 1
`define FCT_BIT_LEVEL_B 0

// ****************************************
// Reset and fixed values
// ****************************************
`define FCT_STATUS_RST 8'h00
`define FCT_CTRL_RST 8'h00
`define FCT_OUTCTL_RST 8'he0
`define FCT_OUTCTL_ONES 3'h7
`define FCT_CNT_RST 16'h0000
`define FCT_CNT_MAX 16'hffff
`define FCT_CMP_RST 16'hffff
`define FCT_FLAGS_RST 4'h0

// ****************************************
// Prescaler taps (divide by 8, 32, 128)
// ****************************************
`define FCT_PRE_WIDTH 7
`define FCT_TAP_DIV8 2
`define FCT_TAP_DIV32 4
`define FCT_TAP_DIV128 6

`endif

// ### rtl/fct_pkg.sv
/*
  Types shared by the free counter timer modules.
  Assumes the defines header supplies all numeric constants.
*/
package fct_pkg;
  typedef enum logic [1:0] {
    FCT_CKS_DIV8,
    FCT_CKS_DIV32,
    FCT_CKS_DIV128,
    FCT_CKS_EXT
  } fct_cks_e;
endpackage

// ### rtl/fct_edge.sv
/*
  Two-flop synchroniser with rise and fall detection for one pin.
  Assumes the pin may be asynchronous to clk; pulses last one clock.
*/
`timescale 1ns/1ps
module fct_edge import fct_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic sync1;
  logic sync2;
  logic last;
  logic next_sync1;
  logic next_sync2;
  logic next_last;

  always_comb begin
    next_sync1 = din;
    next_sync2 = sync1;
    next_last = sync2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      last <= next_last;
    end
  end

  // Edges only from the second stage onward
  assign rise = sync2 & ~last;
  assign fall = ~sync2 & last;
endmodule

// ### rtl/fct_prescale.sv
/*
  Count clock generator: internal divided clocks or external rising edges.
  Assumes ext_rise is already synchronised; tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "fct_defines.svh"
module fct_prescale import fct_pkg::*; #(
  parameter int PRE_WIDTH = `FCT_PRE_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] sel,
  input wire logic ext_rise,
  output logic tick
);
  logic [PRE_WIDTH-1:0] div;
  logic tap_last;
  logic [PRE_WIDTH-1:0] next_div;
  logic next_tap_last;
  logic tap;
  fct_cks_e cks;

  always_comb begin
    cks = fct_cks_e'(sel);
    next_div = div + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
    case (cks)
      FCT_CKS_DIV8: tap = div[`FCT_TAP_DIV8];
      FCT_CKS_DIV32: tap = div[`FCT_TAP_DIV32];
      FCT_CKS_DIV128: tap = div[`FCT_TAP_DIV128];
      default: tap = 1'b0;
    endcase
    next_tap_last = tap;
    // Count on the falling edge of the selected tap; a switch from high to low also counts
    if (cks == FCT_CKS_EXT) begin
      tick = ext_rise;
    end else begin
      tick = tap_last & ~tap;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div <= '0;
      tap_last <= 1'b0;
    end else begin
      div <= next_div;
      tap_last <= next_tap_last;
    end
  end
endmodule

// ### rtl/fct_timer.sv
/*
  Free counter timer: 16-bit counter, two compares, capture, flags, byte staging.
  Assumes an 8-bit bus with one-cycle rd/wr strobes and enable bits held outside.
*/
`timescale 1ns/1ps
`include "fct_defines.svh"
// Function
// - Capture event sets capture flag at status bit 7; software never sets it.
// - A flag clears only after being read as 1 then written 0.
// - Counter equal to compare A sets match A flag, status bit 3.
// - Counter equal to compare B sets match B flag, status bit 2.
// - Counter wrapping from all ones to zero sets wrap flag, bit 1.
// - Clear-on-match-A bit set clears counter on match A; else no clear.
// - Control bit 7 picks capture edge: 0 falling, 1 rising.
// - Clock select 00 /8, 01 /32, 10 /128, 11 external rising edges.
// - Output control bit 4 routes shared compare address to A or B.
// - On match A, pin A takes level bit 1 of output control.
// - On match B, pin B takes level bit 0 of output control.
// - Reset and standby set status, control to 00 and output control to e0.
// - Output control bits 7-5 read 1; other reserved bits read 0.
// - Upper byte write goes to staging; lower byte write loads all 16 bits.
// - Upper byte read latches lower byte; lower read returns latched byte.
// - Compare register reads return both bytes directly, not via staging.
// - After reset both compare pins drive 0 until first match.
// - Counter clear beats a coincident lower-byte counter write.
// - Lower-byte counter write beats a coincident increment.
// - Lower-byte compare write wins and suppresses coincident match.
module fct_timer import fct_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic standby,
  input wire logic module_stop,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic capture_input_pin,
  input wire logic external_count_pin,
  input wire logic [3:0] irq_enable,
  output logic [3:0] irq_req,
  output logic match_a_output_pin,
  output logic match_b_output_pin
);
  // ****************************************
  // State
  // ****************************************
  logic init;
  logic [15:0] free_counter;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [7:0] staging;
  logic [3:0] flags; // capture, match A, match B, wrap
  logic [3:0] armed;
  logic clear_on_match_a;
  logic capture_edge_select;
  logic [1:0] count_clock_sel;
  logic compare_reg_select;
  logic match_a_level;
  logic match_b_level;
  logic cap_pend;
  logic [15:0] next_free_counter;
  logic [15:0] next_compare_value_a;
  logic [15:0] next_compare_value_b;
  logic [15:0] next_capture_value;
  logic [7:0] next_staging;
  logic [3:0] next_flags;
  logic [3:0] next_armed;
  logic next_clear_on_match_a;
  logic next_capture_edge_select;
  logic [1:0] next_count_clock_sel;
  logic next_compare_reg_select;
  logic next_match_a_level;
  logic next_match_b_level;
  logic next_cap_pend;
  logic [7:0] next_rdata;
  logic next_pin_a;
  logic next_pin_b;

  logic tick;
  logic cap_rise;
  logic cap_fall;
  logic ext_rise;
  logic wr_status;
  logic rd_status;
  logic wr_cnt_lo;
  logic wr_cmpa_lo;
  logic wr_cmpb_lo;
  logic rd_cap_hi;
  logic match_a;
  logic match_b;
  logic counter_clear;
  logic wrap_ev;
  logic cap_req;
  logic cap_ev;
  logic [3:0] wbits;
  logic [3:0] clr_ev;

  // Standby and module stop act just like reset
  assign init = srst | standby | module_stop;

  // ****************************************
  // Pin conditioning and count clock
  // ****************************************
  fct_edge u_cap_edge (
    .clk(clk),
    .srst(init),
    .din(capture_input_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  fct_edge u_ext_edge (
    .clk(clk),
    .srst(init),
    .din(external_count_pin),
    .rise(ext_rise),
    .fall()
  );

  fct_prescale #(.PRE_WIDTH(`FCT_PRE_WIDTH)) u_prescale (
    .clk(clk),
    .srst(init),
    .sel(count_clock_sel),
    .ext_rise(ext_rise),
    .tick(tick)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    wr_status = wr && (addr == `FCT_OFS_STATUS);
    rd_status = rd && (addr == `FCT_OFS_STATUS);
    wr_cnt_lo = wr && (addr == `FCT_OFS_CNT_LO);
    wr_cmpa_lo = wr && (addr == `FCT_OFS_CMP_LO) && !compare_reg_select;
    wr_cmpb_lo = wr && (addr == `FCT_OFS_CMP_LO) && compare_reg_select;
    rd_cap_hi = rd && (addr == `FCT_OFS_CAP_HI);
    // Match fires on the count update of the matching value
    match_a = tick && (free_counter == compare_value_a) && !wr_cmpa_lo;
    match_b = tick && (free_counter == compare_value_b) && !wr_cmpb_lo;
    counter_clear = match_a && clear_on_match_a;
    wrap_ev = tick && !counter_clear && !wr_cnt_lo && (free_counter == `FCT_CNT_MAX);
    // Capture during an upper capture read slips one cycle so the staged pair stays coherent
    cap_req = (capture_edge_select ? cap_rise : cap_fall) || cap_pend;
    cap_ev = cap_req && !rd_cap_hi;
    next_cap_pend = cap_req && rd_cap_hi;
    next_capture_value = cap_ev ? free_counter : capture_value;

    if (counter_clear) begin
      next_free_counter = `FCT_CNT_RST;
    end else if (wr_cnt_lo) begin
      next_free_counter = {staging, wdata};
    end else if (tick) begin
      next_free_counter = free_counter + 16'h0001;
    end else begin
      next_free_counter = free_counter;
    end
    next_compare_value_a = wr_cmpa_lo ? {staging, wdata} : compare_value_a;
    next_compare_value_b = wr_cmpb_lo ? {staging, wdata} : compare_value_b;

    // Flags: hardware set wins over a same-cycle clear
    wbits = {wdata[`FCT_BIT_CAP_FLAG], wdata[`FCT_BIT_MATCH_A_FLAG],
             wdata[`FCT_BIT_MATCH_B_FLAG], wdata[`FCT_BIT_WRAP_FLAG]};
    clr_ev = (wr_status ? armed & ~wbits : 4'h0);
    next_flags = (flags & ~clr_ev) | {cap_ev, match_a, match_b, wrap_ev};
    if (wr_status) begin
      next_armed = 4'h0;
    end else if (rd_status) begin
      next_armed = armed | flags;
    end else begin
      next_armed = armed;
    end

    next_clear_on_match_a = clear_on_match_a;
    next_capture_edge_select = capture_edge_select;
    next_count_clock_sel = count_clock_sel;
    next_compare_reg_select = compare_reg_select;
    next_match_a_level = match_a_level;
    next_match_b_level = match_b_level;
    next_staging = staging;
    if (wr) begin
      case (addr)
        `FCT_OFS_STATUS: next_clear_on_match_a = wdata[`FCT_BIT_CLEAR_ON_A];
        `FCT_OFS_CTRL: begin
          next_capture_edge_select = wdata[`FCT_BIT_EDGE_SEL];
          next_count_clock_sel = wdata[`FCT_BIT_CKS_HI:`FCT_BIT_CKS_LO];
        end
        `FCT_OFS_OUTCTL: begin
          next_compare_reg_select = wdata[`FCT_BIT_REG_SEL];
          next_match_a_level = wdata[`FCT_BIT_LEVEL_A];
          next_match_b_level = wdata[`FCT_BIT_LEVEL_B];
        end
        `FCT_OFS_CNT_HI, `FCT_OFS_CMP_HI: next_staging = wdata;
        default: next_staging = staging;
      endcase
    end else if (rd && addr == `FCT_OFS_CNT_HI) begin
      next_staging = free_counter[7:0];
    end else if (rd_cap_hi) begin
      next_staging = capture_value[7:0];
    end

    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `FCT_OFS_STATUS: next_rdata = {flags[3], 3'h0, flags[2:0], clear_on_match_a};
        `FCT_OFS_CNT_HI: next_rdata = free_counter[15:8];
        `FCT_OFS_CNT_LO, `FCT_OFS_CAP_LO: next_rdata = staging;
        `FCT_OFS_CMP_HI: next_rdata = compare_reg_select ? compare_value_b[15:8]
                                                          : compare_value_a[15:8];
        `FCT_OFS_CMP_LO: next_rdata = compare_reg_select ? compare_value_b[7:0]
                                                          : compare_value_a[7:0];
        `FCT_OFS_CTRL: next_rdata = {capture_edge_select, 5'h00, count_clock_sel};
        `FCT_OFS_OUTCTL: next_rdata = {`FCT_OUTCTL_ONES, compare_reg_select, 2'h0,
                                       match_a_level, match_b_level};
        `FCT_OFS_CAP_HI: next_rdata = capture_value[15:8];
        default: next_rdata = 8'h00;
      endcase
    end

    next_pin_a = match_a ? match_a_level : match_a_output_pin;
    next_pin_b = match_b ? match_b_level : match_b_output_pin;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (init) begin
      free_counter <= `FCT_CNT_RST;
      compare_value_a <= `FCT_CMP_RST;
      compare_value_b <= `FCT_CMP_RST;
      capture_value <= `FCT_CNT_RST;
      staging <= 8'h00;
      flags <= `FCT_FLAGS_RST;
      armed <= `FCT_FLAGS_RST;
      clear_on_match_a <= 1'(`FCT_STATUS_RST >> `FCT_BIT_CLEAR_ON_A);
      capture_edge_select <= 1'(`FCT_CTRL_RST >> `FCT_BIT_EDGE_SEL);
      count_clock_sel <= 2'(`FCT_CTRL_RST);
      compare_reg_select <= 1'(`FCT_OUTCTL_RST >> `FCT_BIT_REG_SEL);
      match_a_level <= 1'(`FCT_OUTCTL_RST >> `FCT_BIT_LEVEL_A);
      match_b_level <= 1'(`FCT_OUTCTL_RST);
      cap_pend <= 1'b0;
      rdata <= 8'h00;
      match_a_output_pin <= 1'b0;
      match_b_output_pin <= 1'b0;
    end else begin
      free_counter <= next_free_counter;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      capture_value <= next_capture_value;
      staging <= next_staging;
      flags <= next_flags;
      armed <= next_armed;
      clear_on_match_a <= next_clear_on_match_a;
      capture_edge_select <= next_capture_edge_select;
      count_clock_sel <= next_count_clock_sel;
      compare_reg_select <= next_compare_reg_select;
      match_a_level <= next_match_a_level;
      match_b_level <= next_match_b_level;
      cap_pend <= next_cap_pend;
      rdata <= next_rdata;
      match_a_output_pin <= next_pin_a;
      match_b_output_pin <= next_pin_b;
    end
  end

  assign irq_req = flags & irq_enable;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (init);

  sequence s_cnt_lo_write;
    wr_cnt_lo && !counter_clear;
  endsequence

  sequence s_capture;
    cap_ev ##1 flags[3];
  endsequence

  AST_CAPTURE_COPY: assert property (cap_ev |=> capture_value == $past(free_counter))
    else $error("capture value not copied from counter");
  AST_CAPTURE_NO_SW_SET: assert property (!flags[3] && !cap_ev |=> !flags[3])
    else $error("capture flag set without a capture");
  AST_CLEAR_NEEDS_READ: assert property (
    $fell(flags[2]) && !$past(init) |-> $past(armed[2] && wr_status))
    else $error("match A flag cleared without prior read");
  AST_WRITE_ONE_KEEPS: assert property (
    flags[0] && wr_status && wdata[`FCT_BIT_WRAP_FLAG] |=> flags[0])
    else $error("writing one cleared the wrap flag");
  AST_MATCH_A_FLAG: assert property (
    match_a |=> flags[2] && match_a_output_pin == $past(match_a_level))
    else $error("match A did not set flag and pin");
  AST_MATCH_B_FLAG: assert property (
    match_b |=> flags[1] && match_b_output_pin == $past(match_b_level))
    else $error("match B did not set flag and pin");
  AST_WRAP: assert property (wrap_ev |=> flags[0] && free_counter == `FCT_CNT_RST)
    else $error("wrap did not set flag or reach zero");
  AST_CLEAR_ON_A: assert property (
    match_a && clear_on_match_a |=> free_counter == `FCT_CNT_RST)
    else $error("counter not cleared on match A");
  AST_CNT_WRITE_WINS: assert property (
    s_cnt_lo_write |=> free_counter == {$past(staging), $past(wdata)})
    else $error("lower counter write lost");
  AST_CMP_WRITE_SUPPRESS: assert property (
    wr_cmpb_lo && !flags[1] |=> !flags[1] && compare_value_b == {$past(staging), $past(wdata)})
    else $error("compare write did not win");
  AST_OUTCTL_ONES: assert property (
    rd && addr == `FCT_OFS_OUTCTL |=> rdata[7:5] == `FCT_OUTCTL_ONES)
    else $error("output control reserved bits not one");
  AST_CAP_FLAG_SEQ: assert property (cap_req && !rd_cap_hi |-> s_capture)
    else $error("capture flag not set after capture");
endmodule

// ### test/fct_cpu_model.sv
/*
  Processor core model on the 8-bit peripheral bus of the free counter timer.
  Assumes one-cycle rd/wr strobes, driven at falling edges, read data one cycle later.
*/
`timescale 1ns/1ps
module fct_cpu_model (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  // **********
  // Idle bus
  // **********
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // **********
  // Byte cycles
  // **********
  // Released lines flip so a stale value never looks valid
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    addr = ~a;
  endtask

  // **********
  // Word cycles
  // **********
  // Upper byte always goes first, lower byte second
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a, d[15:8]);
    wr8(a + 4'h1, d[7:0]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd8(a, d[15:8]);
    rd8(a + 4'h1, d[7:0]);
  endtask
endmodule

// ### test/fct_timer_tb_top.sv
/*
  Self-checking bench of the free counter timer: register table loop, then hand tests.
  Assumes the CPU model drives the bus; pins and resets are driven here at falling edges.
*/
`timescale 1ns/1ps
`include "fct_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module fct_timer_tb_top;
  typedef struct {logic w; logic [3:0] a; logic [7:0] wd; logic [7:0] ex;} fct_row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic standby = 1'b0;
  logic module_stop = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic cap_pin = 1'b0;
  logic ext_pin = 1'b0;
  logic [3:0] irq_enable = 4'hf;
  logic [3:0] irq_req;
  logic pin_a;
  logic pin_b;
  logic [7:0] d;
  logic [15:0] v;
  int err_count = 0;
  int compares = 0;
  int exp_cnt;
  fct_row_s rows [12];

  always #5 clk = ~clk;

  fct_timer dut_u (.clk(clk), .srst(srst), .standby(standby), .module_stop(module_stop),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .capture_input_pin(cap_pin), .external_count_pin(ext_pin), .irq_enable(irq_enable),
    .irq_req(irq_req), .match_a_output_pin(pin_a), .match_b_output_pin(pin_b));

  fct_cpu_model cpu_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  // **********
  // Verdict
  // **********
  task automatic final_report();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // External edge arrives through the synchroniser
  task automatic ext_pulse();
    @(negedge clk) ext_pin = 1'b1;
    repeat (4) @(negedge clk);
    ext_pin = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Byte write whose strobe meets the count tick of one external rise
  task automatic tick_wr(input logic [3:0] a, input logic [7:0] wd);
    @(negedge clk) ext_pin = 1'b1;
    @(negedge clk);
    cpu_u.wr8(a, wd);
    ext_pin = 1'b0;
  endtask

  initial begin
    #300us;
    err_count++;
    final_report();
  end

  // **********
  // Tests
  // **********
  initial begin
    rows = '{
      '{0, `FCT_OFS_STATUS, 8'h00, 8'h00}, '{0, `FCT_OFS_CTRL, 8'h00, 8'h00},
      '{0, `FCT_OFS_OUTCTL, 8'h00, 8'he0}, '{0, `FCT_OFS_CMP_HI, 8'h00, 8'hff},
      '{0, `FCT_OFS_CMP_LO, 8'h00, 8'hff}, '{0, `FCT_OFS_CAP_HI, 8'h00, 8'h00},
      '{1, 4'h0, 8'h5a, 8'h00}, '{1, `FCT_OFS_CTRL, 8'hff, 8'h83},
      '{1, `FCT_OFS_OUTCTL, 8'h00, 8'he0}, '{1, `FCT_OFS_STATUS, 8'hf1, 8'h01},
      '{1, `FCT_OFS_STATUS, 8'h00, 8'h00}, '{1, `FCT_OFS_CAP_HI, 8'h12, 8'h00}};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        cpu_u.wr8(rows[i].a, rows[i].wd);
      end
      cpu_u.rd8(rows[i].a, d);
      `CHK(d, rows[i].ex)
    end
    // Internal rates over a 512-cycle window, one tick of slack below and two above for alignment
    for (int i = 0; i < 3; i++) begin
      cpu_u.wr8(`FCT_OFS_CTRL, 8'(i));
      cpu_u.wr16(`FCT_OFS_CNT_HI, 16'h0000);
      repeat (512) @(negedge clk);
      cpu_u.rd16(`FCT_OFS_CNT_HI, v);
      exp_cnt = 512 >> (3 + 2 * i);
      `CHK(int'(v) >= exp_cnt - 1 && int'(v) <= exp_cnt + 2, 1'b1)
    end
    // External clock, one pin pulse, so the counter steps by one
    cpu_u.wr8(`FCT_OFS_CTRL, 8'h03);
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'haa55);
    cpu_u.rd8(`FCT_OFS_CNT_HI, d);
    `CHK(d, 8'haa)
    ext_pulse();
    cpu_u.rd8(`FCT_OFS_CNT_LO, d);
    `CHK(d, 8'h55)
    cpu_u.rd16(`FCT_OFS_CNT_HI, v);
    `CHK(v, 16'haa56)
    cpu_u.wr8(`FCT_OFS_CNT_HI, 8'h77);
    cpu_u.rd8(`FCT_OFS_CNT_HI, d);
    `CHK(d, 8'haa)
    cpu_u.wr8(`FCT_OFS_OUTCTL, 8'h10);
    cpu_u.wr16(`FCT_OFS_CMP_HI, 16'h1234);
    cpu_u.rd8(`FCT_OFS_CNT_HI, d);
    cpu_u.rd8(`FCT_OFS_CMP_LO, d);
    `CHK(d, 8'h34)
    cpu_u.rd8(`FCT_OFS_CMP_HI, d);
    `CHK(d, 8'h12)
    cpu_u.wr8(`FCT_OFS_OUTCTL, 8'h00);
    cpu_u.rd16(`FCT_OFS_CMP_HI, v);
    `CHK(v, 16'hffff)
    // Match A with clearing, pin level and flag handling
    cpu_u.wr16(`FCT_OFS_CMP_HI, 16'h0003);
    cpu_u.wr8(`FCT_OFS_OUTCTL, 8'h03);
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h01);
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'h0000);
    repeat (3) ext_pulse();
    `CHK(pin_a, 1'b0)
    ext_pulse();
    `CHK(pin_a, 1'b1)
    `CHK(irq_req, 4'h4)
    @(negedge clk) irq_enable = 4'hb;
    @(negedge clk);
    `CHK(irq_req, 4'h0)
    irq_enable = 4'hf;
    cpu_u.rd16(`FCT_OFS_CNT_HI, v);
    `CHK(v, 16'h0000)
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h09)
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h09);
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h01);
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h09)
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h01);
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h01)
    // Wrap coinciding with match B at all ones, no clearing selected
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h00);
    cpu_u.wr8(`FCT_OFS_OUTCTL, 8'h13);
    cpu_u.wr16(`FCT_OFS_CMP_HI, 16'hffff);
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'hffff);
    ext_pulse();
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h06)
    `CHK(pin_b, 1'b1)
    // Capture on each selected edge only
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h00);
    cpu_u.wr8(`FCT_OFS_CTRL, 8'h83);
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'h4321);
    @(negedge clk) cap_pin = 1'b1;
    repeat (6) @(negedge clk);
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h80)
    cpu_u.rd16(`FCT_OFS_CAP_HI, v);
    `CHK(v, 16'h4321)
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'h1111);
    @(negedge clk) cap_pin = 1'b0;
    repeat (6) @(negedge clk);
    cpu_u.rd16(`FCT_OFS_CAP_HI, v);
    `CHK(v, 16'h4321)
    cpu_u.wr8(`FCT_OFS_CTRL, 8'h03);
    @(negedge clk) cap_pin = 1'b1;
    repeat (6) @(negedge clk);
    cap_pin = 1'b0;
    repeat (6) @(negedge clk);
    cpu_u.rd16(`FCT_OFS_CAP_HI, v);
    `CHK(v, 16'h1111)
    // Lower-byte writes landing on the edge of an external tick
    cpu_u.wr8(`FCT_OFS_CNT_HI, 8'h12);
    tick_wr(`FCT_OFS_CNT_LO, 8'h34);
    cpu_u.rd16(`FCT_OFS_CNT_HI, v);
    `CHK(v, 16'h1234)
    cpu_u.wr16(`FCT_OFS_CMP_HI, 16'h1234);
    cpu_u.wr8(`FCT_OFS_CMP_HI, 8'h56);
    tick_wr(`FCT_OFS_CMP_LO, 8'h78);
    cpu_u.rd8(`FCT_OFS_STATUS, d);
    `CHK(d, 8'h80)
    cpu_u.rd16(`FCT_OFS_CMP_HI, v);
    `CHK(v, 16'h5678)
    cpu_u.wr8(`FCT_OFS_STATUS, 8'h01);
    cpu_u.wr16(`FCT_OFS_CNT_HI, 16'h0003);
    cpu_u.wr8(`FCT_OFS_CNT_HI, 8'h99);
    tick_wr(`FCT_OFS_CNT_LO, 8'h88);
    cpu_u.rd16(`FCT_OFS_CNT_HI, v);
    `CHK(v, 16'h0000)
    // Each of the three initialising sources in mid-run
    for (int k = 0; k < 3; k++) begin
      cpu_u.wr8(`FCT_OFS_CTRL, 8'h83);
      cpu_u.wr8(`FCT_OFS_OUTCTL, 8'h13);
      @(negedge clk) {module_stop, standby, srst} = 3'(1 << k);
      repeat (2) @(negedge clk);
      {module_stop, standby, srst} = 3'h0;
      `CHK({pin_a, pin_b}, 2'b00)
      cpu_u.rd8(`FCT_OFS_OUTCTL, d);
      `CHK(d, 8'he0)
      cpu_u.rd8(`FCT_OFS_CTRL, d);
      `CHK(d, 8'h00)
      cpu_u.rd8(`FCT_OFS_STATUS, d);
      `CHK(d, 8'h00)
    end
    final_report();
  end
endmodule
